// ==== plld_consts.vh ====
// Constants for the PLL lock detect and monitor control block
// Assumes a register write port of 8-bit address and 8-bit data
`ifndef PLLD_CONSTS_VH
`define PLLD_CONSTS_VH
// ****************************************
// Register addresses
// ****************************************
`define PLLD_ADDR_STATUS_PIN_SELECT_BACKLASH 8'h17
`define PLLD_ADDR_LOCK_DETECT_AND_CAL_CTRL 8'h18
`define PLLD_ADDR_COUNTER_SYNC_AND_PATH_DELAY 8'h19
`define PLLD_ADDR_FREQ_THRESHOLD_LOCK_PIN_SELECT 8'h1A
`define PLLD_ADDR_MONITOR_ENABLE_CTRL 8'h1B
`define PLLD_ADDR_UPDATE 8'h32
// ****************************************
// Reset values
// ****************************************
`define PLLD_RST_17 8'h00
`define PLLD_RST_18 8'h06
`define PLLD_RST_19 8'h00
`define PLLD_RST_1A 8'h00
`define PLLD_RST_1B 8'h00
// ****************************************
// Field positions
// ****************************************
`define PLLD_BKL_LO 0
`define PLLD_LDCNT_LO 5
`define PLLD_LDWIN_BIT 4
`define PLLD_LDDIS_BIT 3
`define PLLD_CALDIV_LO 1
`define PLLD_CALNOW_BIT 0
`define PLLD_SYNC_LO 6
`define PLLD_THR_BIT 6
`define PLLD_UPD_BIT 0
// ****************************************
// Counts and codes
// ****************************************
`define PLLD_LOCK_CNT_0 8'h05
`define PLLD_LOCK_CNT_1 8'h10
`define PLLD_LOCK_CNT_2 8'h40
`define PLLD_LOCK_CNT_3 8'hFF
`define PLLD_BKL_1P3 2'h1
`define PLLD_BKL_2P9 2'h0
`define PLLD_BKL_6P0 2'h2
`define PLLD_SYNC_ASYNC 2'h1
`define PLLD_SYNC_SYNC 2'h2
`define PLLD_PIN_LOCK 6'h00
`define PLLD_PIN_POD 6'h01
`define PLLD_PIN_NOD 6'h02
`define PLLD_PIN_FLOAT 6'h03
`define PLLD_PIN_CURRENT 6'h04
`endif

// ==== plld_cal_divider.v ====
// Calibration clock divider: reference tick divided by 2, 4, 8 or 16
// Assumes ref_tick is one cycle wide per reference clock edge
`timescale 1ns/10ps
module plld_cal_divider (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire [1:0] div_sel,
  input wire ref_tick,
  // Output
  output reg cal_tick
);
  reg [3:0] count;
  wire [3:0] last;

  // Terminal count from the select code
  assign last = (4'h2 << div_sel) - 4'h1;

  // Count reference ticks and pulse on wrap
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count <= 4'h0;
      cal_tick <= 1'b0;
    end else begin
      cal_tick <= 1'b0;
      if (ref_tick) begin
        if (count >= last) begin
          count <= 4'h0;
          cal_tick <= 1'b1;
        end else begin
          count <= count + 4'h1;
        end
      end
    end
  end
endmodule // plld_cal_divider

// ==== plld_lock_detect.v ====
// Digital lock detector with consecutive in-window cycle counter
// Assumes one pfd_cycle pulse per detector cycle with window results
`timescale 1ns/10ps
`include "plld_consts.vh"
module plld_lock_detect (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Control
  input wire [1:0] cnt_sel,
  input wire disable_det,
  // Detector cycle results
  input wire pfd_cycle,
  input wire in_window,
  input wire past_loss,
  // Output
  output reg digital_lock_flag
);
  reg [7:0] good_count;
  wire [7:0] need;

  // Required cycle count for a select code
  function [7:0] need_of;
    input [1:0] sel;
    begin
      case (sel)
        2'h0: need_of = `PLLD_LOCK_CNT_0;
        2'h1: need_of = `PLLD_LOCK_CNT_1;
        2'h2: need_of = `PLLD_LOCK_CNT_2;
        default: need_of = `PLLD_LOCK_CNT_3;
      endcase
    end
  endfunction

  assign need = need_of(cnt_sel);

  // Count in-window cycles, hold lock until loss threshold
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      good_count <= 8'h00;
      digital_lock_flag <= 1'b0;
    end else if (disable_det) begin
      good_count <= 8'h00;
      digital_lock_flag <= 1'b0;
    end else if (pfd_cycle) begin
      if (!in_window) begin
        good_count <= 8'h00;
      end else if (good_count < need) begin
        good_count <= good_count + 8'h01;
      end
      if (digital_lock_flag && past_loss) begin
        digital_lock_flag <= 1'b0;
      end else if (in_window && {1'b0, good_count} + 9'h001 >= {1'b0, need}) begin
        digital_lock_flag <= 1'b1;
      end
    end
  end
endmodule // plld_lock_detect

// ==== plld_ctrl.v ====
// PLL lock detect, calibration and lock indicator pin control
// Assumes register writes come as one-cycle strobes with address and data
// What this block does
// - Two-bit code picks antibacklash width: 2.9, 1.3, 6.0, 2.9 ns.
// - Lock reported after 5, 16, 64 or 255 consecutive in-window cycles.
// - Lock set inside window, held until loss threshold; bit picks range.
// - Disable bit turns digital lock detection off.
// - Calibration clock is reference divided by 2, 4, 8 or 16.
// - Calibration starts only on active calibrate bit rising 0 to 1.
// - Clearing calibrate bit discards completed calibration.
// - Sync pin: 01 async counter reset, 10 sync reset, else nothing.
// - Threshold bit selects high or low reference valid threshold.
// - Top bit clear: lock level, open drain, float or current source.
// - Other codes with top bit clear drive the pin to ground.
// - Top bit set: monitor set, low sixteen high except 20 and 2F, upper sixteen low except 30 and 3F.
// - One level is lock AND selected status AND oscillator status.
// - Selected reference low for first, high for second; inverted above.
// - Writes take effect only on self-clearing update strobe.
`timescale 1ns/10ps
`include "plld_consts.vh"
module plld_ctrl (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register write and read port
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [7:0] rd_addr,
  input wire rd_active,
  output reg [7:0] rd_data,
  // Detector inputs
  input wire pfd_cycle,
  input wire in_window_high,
  input wire in_window_low,
  input wire past_loss_high,
  input wire past_loss_low,
  input wire ref_tick,
  // Reference status
  input wire first_reference_input,
  input wire second_reference_input,
  input wire ref_selected_clk,
  input wire ref_unselected_clk,
  input wire first_ref_above_high,
  input wire first_ref_above_low,
  input wire second_ref_above_high,
  input wire second_ref_above_low,
  input wire second_ref_selected,
  input wire osc_freq_ok,
  input wire holdover_active,
  input wire loop_supply_level,
  input wire analog_lock,
  // Sync pin
  input wire sync_pin_n,
  // Calibration
  input wire cal_done,
  output reg cal_start,
  output reg cal_discard,
  output wire cal_tick,
  // Counter resets
  output wire counter_reset_async,
  output reg counter_reset_sync,
  // Antibacklash and window range
  output reg [1:0] backlash_code,
  output reg window_low_range,
  // Reference valid
  output wire first_ref_valid,
  output wire second_ref_valid,
  // Lock indicator pin
  output reg lock_indicator_pin_out,
  output reg lock_indicator_pin_oe,
  output reg current_source_output,
  output wire digital_lock_flag
);
  // ****************************************
  // Buffer and active registers
  // ****************************************
  reg [7:0] buf_17;
  reg [7:0] buf_18;
  reg [7:0] buf_19;
  reg [7:0] buf_1a;
  reg [7:0] buf_1b;
  reg [7:0] act_17;
  reg [7:0] act_18;
  reg [7:0] act_19;
  reg [7:0] act_1a;
  reg [7:0] act_1b;
  reg cal_prev;
  reg next_pin;
  reg next_oe;
  wire update;
  wire in_window;
  wire past_loss;
  wire sel_status;
  wire unsel_status;
  wire [5:0] pin_sel;
  wire [4:0] low_code;
  reg mon_level;

  assign update = wr_en && wr_addr == `PLLD_ADDR_UPDATE && wr_data[`PLLD_UPD_BIT];

  // Buffer writes, active copy on update
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      buf_17 <= `PLLD_RST_17;
      buf_18 <= `PLLD_RST_18;
      buf_19 <= `PLLD_RST_19;
      buf_1a <= `PLLD_RST_1A;
      buf_1b <= `PLLD_RST_1B;
      act_17 <= `PLLD_RST_17;
      act_18 <= `PLLD_RST_18;
      act_19 <= `PLLD_RST_19;
      act_1a <= `PLLD_RST_1A;
      act_1b <= `PLLD_RST_1B;
    end else begin
      if (wr_en) begin
        case (wr_addr)
          `PLLD_ADDR_STATUS_PIN_SELECT_BACKLASH: buf_17 <= wr_data;
          `PLLD_ADDR_LOCK_DETECT_AND_CAL_CTRL: buf_18 <= {1'b0, wr_data[6:0]};
          `PLLD_ADDR_COUNTER_SYNC_AND_PATH_DELAY: buf_19 <= wr_data;
          `PLLD_ADDR_FREQ_THRESHOLD_LOCK_PIN_SELECT: buf_1a <= {1'b0, wr_data[6:0]};
          `PLLD_ADDR_MONITOR_ENABLE_CTRL: buf_1b <= wr_data;
          default: ;
        endcase
      end
      if (update) begin
        act_17 <= buf_17;
        act_18 <= buf_18;
        act_19 <= buf_19;
        act_1a <= buf_1a;
        act_1b <= buf_1b;
      end
    end
  end

  // Read back buffer or active bank
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_data <= 8'h00;
    end else begin
      case (rd_addr)
        `PLLD_ADDR_STATUS_PIN_SELECT_BACKLASH: rd_data <= rd_active ? act_17 : buf_17;
        `PLLD_ADDR_LOCK_DETECT_AND_CAL_CTRL: rd_data <= rd_active ? act_18 : buf_18;
        `PLLD_ADDR_COUNTER_SYNC_AND_PATH_DELAY: rd_data <= rd_active ? act_19 : buf_19;
        `PLLD_ADDR_FREQ_THRESHOLD_LOCK_PIN_SELECT: rd_data <= rd_active ? act_1a : buf_1a;
        `PLLD_ADDR_MONITOR_ENABLE_CTRL: rd_data <= rd_active ? act_1b : buf_1b;
        `PLLD_ADDR_UPDATE: rd_data <= {1'b0, cal_done, 5'h00, digital_lock_flag};
        default: rd_data <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Antibacklash and window range
  // ****************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      backlash_code <= `PLLD_BKL_2P9;
      window_low_range <= 1'b0;
    end else begin
      backlash_code <= act_17[`PLLD_BKL_LO +: 2];
      window_low_range <= act_18[`PLLD_LDWIN_BIT];
    end
  end

  assign in_window = act_18[`PLLD_LDWIN_BIT] ? in_window_low : in_window_high;
  assign past_loss = act_18[`PLLD_LDWIN_BIT] ? past_loss_low : past_loss_high;

  // ****************************************
  // Lock detector and calibration divider
  // ****************************************
  plld_lock_detect u_lock (
    .clk(clk),
    .rstn(rstn),
    .cnt_sel(act_18[`PLLD_LDCNT_LO +: 2]),
    .disable_det(act_18[`PLLD_LDDIS_BIT]),
    .pfd_cycle(pfd_cycle),
    .in_window(in_window),
    .past_loss(past_loss),
    .digital_lock_flag(digital_lock_flag)
  );

  plld_cal_divider u_div (
    .clk(clk),
    .rstn(rstn),
    .div_sel(act_18[`PLLD_CALDIV_LO +: 2]),
    .ref_tick(ref_tick),
    .cal_tick(cal_tick)
  );

  // Calibrate bit edge detection on active bank
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cal_prev <= 1'b0;
      cal_start <= 1'b0;
      cal_discard <= 1'b0;
    end else begin
      cal_prev <= act_18[`PLLD_CALNOW_BIT];
      cal_start <= act_18[`PLLD_CALNOW_BIT] && !cal_prev;
      cal_discard <= !act_18[`PLLD_CALNOW_BIT] && cal_prev;
    end
  end

  // ****************************************
  // Sync pin counter reset
  // ****************************************
  assign counter_reset_async = !sync_pin_n &&
    act_19[`PLLD_SYNC_LO +: 2] == `PLLD_SYNC_ASYNC;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_reset_sync <= 1'b0;
    end else begin
      counter_reset_sync <= !sync_pin_n &&
        act_19[`PLLD_SYNC_LO +: 2] == `PLLD_SYNC_SYNC;
    end
  end

  // ****************************************
  // Reference valid threshold
  // ****************************************
  assign first_ref_valid = act_1a[`PLLD_THR_BIT] ? first_ref_above_low :
    first_ref_above_high;
  assign second_ref_valid = act_1a[`PLLD_THR_BIT] ? second_ref_above_low :
    second_ref_above_high;

  assign sel_status = second_ref_selected ? second_ref_valid : first_ref_valid;
  assign unsel_status = second_ref_selected ? first_ref_valid : second_ref_valid;

  // ****************************************
  // Lock indicator pin multiplexer
  // ****************************************
  assign pin_sel = act_1a[5:0];
  assign low_code = pin_sel[4:0];

  // Monitor set level for the lower four code bits
  always @* begin
    case (low_code[3:0])
      4'h0: mon_level = low_code[4] ? loop_supply_level : 1'b0;
      4'h1: mon_level = first_reference_input;
      4'h2: mon_level = second_reference_input;
      4'h3: mon_level = ref_selected_clk;
      4'h4: mon_level = ref_unselected_clk;
      4'h5: mon_level = sel_status;
      4'h6: mon_level = unsel_status;
      4'h7: mon_level = first_ref_valid;
      4'h8: mon_level = second_ref_valid;
      4'h9: mon_level = first_ref_valid && second_ref_valid;
      4'hA: mon_level = digital_lock_flag && sel_status && osc_freq_ok;
      4'hB: mon_level = osc_freq_ok;
      4'hC: mon_level = second_ref_selected;
      4'hD: mon_level = digital_lock_flag;
      4'hE: mon_level = holdover_active;
      default: mon_level = 1'b0;
    endcase
  end

  // Pin level and enable selection
  always @* begin
    next_pin = 1'b0;
    next_oe = 1'b1;
    if (pin_sel[5]) begin
      if (low_code == 5'h00 || low_code == 5'h10 || low_code[3:0] == 4'hF) begin
        next_pin = low_code == 5'h10 ? loop_supply_level : 1'b0;
      end else begin
        next_pin = mon_level ^ low_code[4];
      end
    end else begin
      case (pin_sel)
        `PLLD_PIN_LOCK: next_pin = digital_lock_flag;
        `PLLD_PIN_POD: begin
          next_pin = 1'b1;
          next_oe = analog_lock;
        end
        `PLLD_PIN_NOD: begin
          next_pin = 1'b0;
          next_oe = !analog_lock;
        end
        `PLLD_PIN_FLOAT: next_oe = 1'b0;
        `PLLD_PIN_CURRENT: next_oe = 1'b0;
        default: next_pin = 1'b0;
      endcase
    end
  end

  // Register pin outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lock_indicator_pin_out <= 1'b0;
      lock_indicator_pin_oe <= 1'b1;
      current_source_output <= 1'b0;
    end else begin
      lock_indicator_pin_out <= next_pin;
      lock_indicator_pin_oe <= next_oe;
      current_source_output <= pin_sel == `PLLD_PIN_CURRENT && digital_lock_flag;
    end
  end
endmodule // plld_ctrl

// ==== plld_pin_board.sv ====
// Board-side model watching the lock indicator pin
// Assumes the block under test is the only driver of the pin
`timescale 1ns/10ps
module plld_pin_board (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Pin driver from the block
  input wire pin_out,
  input wire pin_oe,
  // Level seen on the board
  output wire pin_level
);
  reg last;
  // Undriven pin shows the inverse of its last level
  assign pin_level = pin_oe ? pin_out : ~last;
  // Remember the last level
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      last <= 1'h0;
    else
      last <= pin_level;
  end
endmodule // plld_pin_board

// ==== plld_ctrl_asserts.sv ====
// Assertions on the ports of the lock detect and monitor control block
// Assumes one clock and the active-low asynchronous reset
`timescale 1ns/10ps
module plld_ctrl_asserts (
  // Clock and reset
  input wire clk,
  input wire rstn,
  // Register writes and detector inputs
  input wire wr_en,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire pfd_cycle,
  input wire sync_pin_n,
  // Watched outputs
  input wire cal_start,
  input wire cal_tick,
  input wire counter_reset_async,
  input wire [1:0] backlash_code,
  input wire window_low_range,
  input wire lock_indicator_pin_oe,
  input wire current_source_output,
  input wire digital_lock_flag
);
  reg [2:0] uh;
  // Update strobes seen at the last three edges
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      uh <= 3'h0;
    else
      uh <= {uh[1:0], wr_en && wr_addr == 8'h32 && wr_data[0]};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  bkl_hold_a: assert property ($changed(backlash_code) |-> (|uh))
    else $error("backlash code moved without update");
  win_hold_a: assert property ($changed(window_low_range) |-> (|uh))
    else $error("window range moved without update");
  cal_cause_a: assert property (cal_start |-> (|uh))
    else $error("calibration start without update");
  lock_rise_a: assert property ($rose(digital_lock_flag) |-> $past(pfd_cycle))
    else $error("lock set outside a detector cycle");
  lock_fall_a: assert property ($fell(digital_lock_flag) |-> $past(pfd_cycle) || (|uh))
    else $error("lock dropped without cause");
  sync_pin_a: assert property (counter_reset_async |-> !sync_pin_n)
    else $error("async counter reset with sync pin idle");
  cur_src_a: assert property (current_source_output |-> !lock_indicator_pin_oe)
    else $error("current source while pin driven");
  tick_pulse_a: assert property (cal_tick |=> !cal_tick)
    else $error("calibration tick wider than a cycle");
endmodule // plld_ctrl_asserts
bind plld_ctrl plld_ctrl_asserts u_chk (.clk, .rstn, .wr_en, .wr_addr, .wr_data, .pfd_cycle,
  .sync_pin_n, .cal_start, .cal_tick, .counter_reset_async, .backlash_code, .window_low_range,
  .lock_indicator_pin_oe, .current_source_output, .digital_lock_flag);

// ==== plld_ctrl_tb.sv ====
// Self-checking bench for the lock detect and monitor control block
// Assumes the design, the checker and the pin board model are compiled first
`timescale 1ns/10ps
module plld_ctrl_tb;
  logic clk = 1'h0;
  logic rstn, wr_en, rd_active, pfd_cycle, in_window_high, past_loss_high, ref_tick, sync_pin_n;
  logic thr, lk;
  logic [1:0] pb, pe;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [15:0] rs, seed = 16'h0001;
  logic [5:0] codes [12] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h20, 6'h2A, 6'h2C, 6'h2D,
    6'h30, 6'h3A, 6'h3C};
  wire [7:0] rd_data;
  wire [1:0] backlash_code;
  wire cal_start, cal_discard, cal_tick, counter_reset_async, counter_reset_sync;
  wire window_low_range, first_ref_valid, pin_out, pin_oe, pin_level;
  wire current_source_output, digital_lock_flag;
  int num_errors = 0;
  int n_compared = 0;
  int n;
  // Clock at 100 MHz
  always #5 clk = ~clk;
  // Block under test and the board watching its pin
  plld_ctrl DUT (.clk, .rstn, .wr_en, .wr_addr, .wr_data, .rd_addr, .rd_active, .rd_data,
    .pfd_cycle, .in_window_high, .in_window_low(rs[14]), .past_loss_high,
    .past_loss_low(rs[15]), .ref_tick, .first_reference_input(rs[9]),
    .second_reference_input(rs[10]), .ref_selected_clk(rs[11]), .ref_unselected_clk(rs[12]),
    .first_ref_above_high(rs[0]), .first_ref_above_low(rs[1]), .second_ref_above_high(rs[2]),
    .second_ref_above_low(rs[3]), .second_ref_selected(rs[4]), .osc_freq_ok(rs[5]),
    .holdover_active(rs[6]), .loop_supply_level(rs[7]), .analog_lock(rs[8]), .sync_pin_n,
    .cal_done(rs[13]), .cal_start, .cal_discard, .cal_tick, .counter_reset_async,
    .counter_reset_sync, .backlash_code, .window_low_range, .first_ref_valid,
    .second_ref_valid(), .lock_indicator_pin_out(pin_out), .lock_indicator_pin_oe(pin_oe),
    .current_source_output, .digital_lock_flag);
  plld_pin_board u_board (.clk, .rstn, .pin_out, .pin_oe, .pin_level);
  // Random source and expected pin drive {oe, level}
  function [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function [1:0] pin_exp(input [5:0] c);
    logic sv_ok;
    sv_ok = rs[4] ? (thr ? rs[3] : rs[2]) : (thr ? rs[1] : rs[0]);
    case (c)
      6'h00, 6'h2D: pin_exp = {1'h1, lk};
      6'h01: pin_exp = {rs[8], 1'h1};
      6'h03, 6'h04: pin_exp = 2'h0;
      6'h2A: pin_exp = {1'h1, lk & sv_ok & rs[5]};
      6'h3A: pin_exp = {1'h1, ~(lk & sv_ok & rs[5])};
      6'h2C: pin_exp = {1'h1, rs[4]};
      6'h3C: pin_exp = {1'h1, ~rs[4]};
      6'h30: pin_exp = {1'h1, rs[7]};
      default: pin_exp = 2'h2;
    endcase
  endfunction
  // Compare, write, update and wait helpers
  task chk(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge clk);
    wr_en <= 1'h1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'h0;
  endtask
  task upd(input [7:0] a, input [7:0] d);
    wr(a, d);
    wr(8'h32, 8'h01);
  endtask
  task settle(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task pc(input int k, input logic w, input logic l);
    repeat (k) begin
      @(posedge clk);
      pfd_cycle <= 1'h1;
      in_window_high <= w;
      past_loss_high <= l;
      @(posedge clk);
      pfd_cycle <= 1'h0;
    end
    #2;
  endtask
  task seen(input [7:0] d, input logic w, input logic e);
    logic s;
    s = 1'h0;
    upd(8'h18, d);
    repeat (5) begin
      settle(1);
      s = s | (w ? cal_discard : cal_start);
    end
    chk(s, e);
  endtask
  task test_done;
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Watchdog
  initial begin
    #900000;
    num_errors++;
    test_done;
  end
  // Main sequence; holdover enables are never touched here
  initial begin
    {rstn, wr_en, rd_active, pfd_cycle, in_window_high, past_loss_high} = 6'h00;
    {wr_addr, wr_data, rd_addr, rs} = 40'h0;
    {ref_tick, sync_pin_n, pb} = 4'hC;
    repeat (2) @(posedge clk);
    rstn <= 1'h1;
    settle(1);
    chk(pin_oe, 1'h1);
    chk(digital_lock_flag, 1'h0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      rd_addr <= i < 5 ? 8'h17 + i[7:0] : 8'h40;
      settle(2);
      chk(rd_data, i == 1 ? 8'h06 : 8'h00);
    end
    // All four width codes tried here; a host would keep the default
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      wr(8'h17, {seed[7:2], i[1:0]});
      wr(8'h18, {3'h0, i[0], 4'h6});
      settle(3);
      chk(backlash_code, pb);
      wr(8'h32, 8'h01);
      settle(3);
      chk(backlash_code, i[1:0]);
      chk(window_low_range, i[0]);
      pb = i[1:0];
    end
    // Active bank readback ignores a pending buffer write
    @(posedge clk);
    rd_active <= 1'h1;
    rd_addr <= 8'h17;
    wr(8'h17, 8'h00);
    settle(2);
    chk(rd_data[1:0], pb);
    for (int k = 0; k < 4; k++) begin
      n = k == 0 ? 5 : k == 1 ? 16 : k == 2 ? 64 : 255;
      upd(8'h18, {1'h0, k[1:0], 5'h06});
      pc(1, 1'h0, 1'h0);
      pc(n - 1, 1'h1, 1'h0);
      pc(1, 1'h0, 1'h0);
      pc(n - 1, 1'h1, 1'h0);
      chk(digital_lock_flag, 1'h0);
      pc(1, 1'h1, 1'h0);
      chk(digital_lock_flag, 1'h1);
      pc(1, 1'h1, 1'h1);
      chk(digital_lock_flag, 1'h0);
    end
    upd(8'h18, 8'h06);
    pc(5, 1'h1, 1'h0);
    upd(8'h18, 8'h0E);
    pc(6, 1'h1, 1'h0);
    chk(digital_lock_flag, 1'h0);
    upd(8'h18, 8'h06);
    pc(1, 1'h0, 1'h0);
    pc(5, 1'h1, 1'h0);
    lk = 1'h1;
    chk(digital_lock_flag, lk);
    seen(8'h07, 1'h0, 1'h1);
    seen(8'h07, 1'h0, 1'h0);
    seen(8'h06, 1'h1, 1'h1);
    // Every divider tried; the clock here is slow enough for all
    for (int c = 0; c < 4; c++) begin
      upd(8'h18, {5'h00, c[1:0], 1'h0});
      settle(4);
      n = 0;
      repeat (64) begin
        settle(1);
        n += cal_tick;
      end
      chk(n[7:0], 8'h40 >> (c + 1));
    end
    @(posedge clk);
    sync_pin_n <= 1'h0;
    for (int c = 0; c < 4; c++) begin
      upd(8'h19, {c[1:0], 6'h00});
      settle(3);
      chk(counter_reset_async, c == 1);
      chk(counter_reset_sync, c == 2);
    end
    // Last code of either group is left out
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(seed);
      thr = seed[3] ^ seed[9];
      @(posedge clk);
      rs <= seed;
      upd(8'h1A, {1'h0, thr, codes[i]});
      settle(3);
      pe = pin_exp(codes[i]);
      chk(pin_oe, pe[1]);
      if (pe[1])
        chk(pin_level, pe[0]);
      chk(current_source_output, codes[i] == 6'h04 && lk);
      chk(first_ref_valid, thr ? rs[1] : rs[0]);
    end
    test_done;
  end
endmodule // plld_ctrl_tb
